// ===== design/dsq_pkg.sv
// Package of the drive sequencing state machine: state codes,
// register map, field positions, reset values and carrier structs.
// Assumes one 20 MHz clock domain shared by all users of the package.
package dsq_pkg;

  // ==========================================================
  // Sequencing state codes
  typedef enum logic [2:0] {
    DSQ_NOT_READY  = 3'h0,
    DSQ_START_DIS  = 3'h1,
    DSQ_START_EN   = 3'h2,
    DSQ_SWITCH_ON  = 3'h3,
    DSQ_ENABLED    = 3'h4,
    DSQ_FAST_HALT  = 3'h5,
    DSQ_TRIP_ACT   = 3'h6,
    DSQ_TRIPPED    = 3'h7
  } dsq_state_t;

  // ==========================================================
  // Register map
  localparam int          DSQ_ADDR_W      = 8;
  localparam int          DSQ_DATA_W      = 32;
  localparam logic [7:0]  DSQ_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  DSQ_OFS_STATUS  = 8'h04;

  // Control register fields
  localparam int          DSQ_CTRL_COAST_MODE = 0;
  localparam int          DSQ_CTRL_RECONFIG   = 1;
  localparam int          DSQ_CTRL_REINIT     = 2;
  localparam logic        DSQ_RST_COAST_MODE  = 1'b0;
  localparam logic        DSQ_RST_RECONFIG    = 1'b0;

  // Status register fields
  localparam int          DSQ_STAT_STATE_LSB  = 0;
  localparam int          DSQ_STAT_FLAGS_LSB  = 8;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic run;
    logic jog;
    logic coast_halt_n;
    logic fast_halt_n;
    logic drive_enable;
    logic trip;
    logic trip_reset;
  } dsq_cmd_t;

  typedef struct packed {
    logic init_done;
    logic stack_quenched;
    logic fh_timer_expired;
    logic at_zero_setpoint;
    logic stop_done;
  } dsq_env_t;

  typedef struct packed {
    logic tripped;
    logic running;
    logic jogging;
    logic stopping;
    logic contactor;
    logic switch_on_en;
    logic switched_on;
    logic ready;
    logic healthy;
  } dsq_status_t;

  localparam dsq_status_t DSQ_RST_STATUS = 9'h001;

endpackage

// ===== design/dsq_seq.sv
// Drive sequencing state machine with its small register port.
// Command and environment inputs come from logic on the same clock.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

module dsq_seq
  import dsq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire dsq_cmd_t              cmd,
  input  wire dsq_env_t              env,
  input  wire logic [DSQ_ADDR_W-1:0] addr,
  input  wire logic [DSQ_DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [DSQ_DATA_W-1:0] rdata,
  output logic      [2:0]            state_code,
  output dsq_status_t                status
);

  // ==========================================================
  // Declarations
  dsq_state_t               state_r;
  dsq_state_t               state_nxt;
  dsq_status_t              status_r;
  dsq_status_t              status_nxt;
  logic                     jog_act_r;
  logic                     jog_act_nxt;
  logic                     rst_prev_r;
  logic                     rst_prev_nxt;
  logic                     coast_mode_r;
  logic                     coast_mode_nxt;
  logic                     reconfig_r;
  logic                     reconfig_nxt;
  logic [DSQ_DATA_W-1:0]    rdata_r;
  logic [DSQ_DATA_W-1:0]    rdata_nxt;
  logic                     reinit;
  logic                     reset_edge;
  logic                     idle_cmd;
  logic                     halt_low;

  // ==========================================================
  // Helpers
  function automatic logic in_range(input dsq_state_t s,
                                    input dsq_state_t lo,
                                    input dsq_state_t hi);
    in_range = (s >= lo) && (s <= hi);
  endfunction

  assign reinit     = wr && (addr == DSQ_OFS_CTRL) && wdata[DSQ_CTRL_REINIT];
  assign reset_edge = cmd.trip_reset && !rst_prev_r;
  assign idle_cmd   = !cmd.run && !cmd.jog;
  assign halt_low   = !cmd.coast_halt_n || !cmd.fast_halt_n;

  // ==========================================================
  // Register port
  always_comb begin
    coast_mode_nxt = coast_mode_r;
    reconfig_nxt   = reconfig_r;
    rdata_nxt      = '0;
    if (wr && (addr == DSQ_OFS_CTRL)) begin
      coast_mode_nxt = wdata[DSQ_CTRL_COAST_MODE];
      reconfig_nxt   = wdata[DSQ_CTRL_RECONFIG];
    end
    if (rd) begin
      case (addr)
        DSQ_OFS_CTRL: begin
          rdata_nxt[DSQ_CTRL_COAST_MODE] = coast_mode_r;
          rdata_nxt[DSQ_CTRL_RECONFIG]   = reconfig_r;
        end
        DSQ_OFS_STATUS: begin
          rdata_nxt[DSQ_STAT_STATE_LSB +: 3] = state_r;
          rdata_nxt[DSQ_STAT_FLAGS_LSB +: $bits(dsq_status_t)] = status_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      coast_mode_r <= DSQ_RST_COAST_MODE;
      reconfig_r   <= DSQ_RST_RECONFIG;
      rdata_r      <= '0;
    end else begin
      coast_mode_r <= coast_mode_nxt;
      reconfig_r   <= reconfig_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // ==========================================================
  // State transitions
  always_comb begin
    state_nxt    = state_r;
    rst_prev_nxt = cmd.trip_reset;
    if (reinit) begin
      state_nxt = DSQ_NOT_READY;
    end else begin
      case (state_r)
        DSQ_NOT_READY: begin
          if (env.init_done && !reconfig_r) begin
            state_nxt = DSQ_START_DIS;
          end
        end
        DSQ_START_DIS: begin
          if (cmd.trip) begin
            state_nxt = DSQ_TRIP_ACT;
          end else if (idle_cmd && !halt_low) begin
            state_nxt = DSQ_START_EN;
          end
        end
        DSQ_START_EN: begin
          if (cmd.trip) begin
            state_nxt = DSQ_TRIP_ACT;
          end else if (halt_low) begin
            state_nxt = DSQ_START_DIS;
          end else if (cmd.run || cmd.jog) begin
            state_nxt = DSQ_SWITCH_ON;
          end
        end
        DSQ_SWITCH_ON: begin
          if (cmd.trip) begin
            state_nxt = DSQ_TRIP_ACT;
          end else if (halt_low) begin
            state_nxt = DSQ_START_DIS;
          end else if (idle_cmd) begin
            state_nxt = DSQ_START_EN;
          end else if (cmd.drive_enable) begin
            state_nxt = DSQ_ENABLED;
          end
        end
        DSQ_ENABLED: begin
          if (cmd.trip) begin
            state_nxt = DSQ_TRIP_ACT;
          end else if (!cmd.coast_halt_n) begin
            state_nxt = DSQ_START_DIS;
          end else if (!cmd.fast_halt_n) begin
            state_nxt = DSQ_FAST_HALT;
          end else if (!cmd.drive_enable) begin
            state_nxt = DSQ_SWITCH_ON;
          end else if (idle_cmd && env.stop_done) begin
            state_nxt = DSQ_START_EN;
          end
        end
        DSQ_FAST_HALT: begin
          if (cmd.trip) begin
            state_nxt = DSQ_TRIP_ACT;
          end else if (env.fh_timer_expired || coast_mode_r ||
                       env.at_zero_setpoint) begin
            state_nxt = DSQ_START_DIS;
          end
        end
        DSQ_TRIP_ACT: begin
          if (env.stack_quenched) begin
            state_nxt = DSQ_TRIPPED;
          end
        end
        DSQ_TRIPPED: begin
          if (reset_edge && !cmd.trip) begin
            state_nxt = DSQ_START_DIS;
          end
        end
        default: begin
          state_nxt = DSQ_NOT_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r    <= DSQ_NOT_READY;
      rst_prev_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      rst_prev_r <= rst_prev_nxt;
    end
  end

  // ==========================================================
  // Status outputs from the current state
  always_comb begin
    jog_act_nxt = (state_r == DSQ_ENABLED) &&
                  ((cmd.jog && !cmd.run) ||
                   (jog_act_r && !cmd.run && !env.stop_done));
    status_nxt              = '0;
    status_nxt.tripped      = in_range(state_r, DSQ_TRIP_ACT,
                                       DSQ_TRIPPED);
    status_nxt.running      = (state_r == DSQ_ENABLED);
    status_nxt.jogging      = (state_r == DSQ_ENABLED) && jog_act_r;
    status_nxt.stopping     = (state_r == DSQ_FAST_HALT) ||
                              ((state_r == DSQ_ENABLED) && idle_cmd &&
                               !env.stop_done);
    status_nxt.switch_on_en = in_range(state_r, DSQ_START_EN,
                                       DSQ_TRIP_ACT);
    status_nxt.switched_on  = in_range(state_r, DSQ_SWITCH_ON,
                                       DSQ_TRIP_ACT);
    status_nxt.ready        = status_nxt.switched_on;
    case (state_r)
      DSQ_START_DIS, DSQ_START_EN: begin
        status_nxt.contactor = status_r.contactor;
      end
      DSQ_NOT_READY, DSQ_TRIPPED: begin
        status_nxt.contactor = 1'b0;
      end
      default: begin
        status_nxt.contactor = 1'b1;
      end
    endcase
    case (state_r)
      DSQ_TRIP_ACT: begin
        status_nxt.healthy = 1'b0;
      end
      DSQ_TRIPPED: begin
        status_nxt.healthy = idle_cmd;
      end
      default: begin
        status_nxt.healthy = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_r  <= DSQ_RST_STATUS;
      jog_act_r <= 1'b0;
    end else begin
      status_r  <= status_nxt;
      jog_act_r <= jog_act_nxt;
    end
  end

  assign state_code = state_r;
  assign status     = status_r;
  assign rdata      = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_trip_cause;
    in_range(state_r, DSQ_START_DIS, DSQ_FAST_HALT) && cmd.trip && !reinit;
  endsequence

  sequence s_quench;
    (state_r == DSQ_TRIP_ACT) && env.stack_quenched && !reinit;
  endsequence

  property p_reinit;
    reinit |=> (state_r == DSQ_NOT_READY) ##1 (status_r.healthy &&
      !status_r.contactor);
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit did not reach not ready");

  property p_trip_enter;
    s_trip_cause |=> (state_r == DSQ_TRIP_ACT) ##1
      (status_r.tripped && !status_r.healthy);
  endproperty
  a_trip_enter: assert property (p_trip_enter)
    else $error("trip not taken with tripped flag");

  property p_start_en;
    (state_r == DSQ_START_DIS) && !cmd.trip && idle_cmd && !halt_low &&
      !reinit |=> (state_r == DSQ_START_EN);
  endproperty
  a_start_en: assert property (p_start_en)
    else $error("start enabled not reached");

  property p_halt_drop;
    in_range(state_r, DSQ_START_EN, DSQ_SWITCH_ON) && !cmd.trip &&
      halt_low && !reinit |=> (state_r == DSQ_START_DIS);
  endproperty
  a_halt_drop: assert property (p_halt_drop)
    else $error("halt did not disable start");

  property p_no_switch_on;
    (state_r == DSQ_START_DIS) |=> (state_r != DSQ_SWITCH_ON);
  endproperty
  a_no_switch_on: assert property (p_no_switch_on)
    else $error("switch on from start disabled");

  property p_fast_exit;
    (state_r == DSQ_FAST_HALT) && !cmd.trip && !reinit &&
      (env.fh_timer_expired || coast_mode_r || env.at_zero_setpoint)
      |=> (state_r == DSQ_START_DIS);
  endproperty
  a_fast_exit: assert property (p_fast_exit)
    else $error("fast halt did not end");

  property p_quench;
    s_quench |=> (state_r == DSQ_TRIPPED) ##1 status_r.tripped;
  endproperty
  a_quench: assert property (p_quench)
    else $error("quench did not reach tripped");

  property p_tripped_hold;
    (state_r == DSQ_TRIPPED) && !(reset_edge && !cmd.trip) && !reinit
      |=> (state_r == DSQ_TRIPPED);
  endproperty
  a_tripped_hold: assert property (p_tripped_hold)
    else $error("tripped left without reset edge");

  property p_running;
    status_r.running == ($past(state_r) == DSQ_ENABLED);
  endproperty
  a_running: assert property (p_running)
    else $error("running flag wrong");

  property p_contactor;
    in_range(state_r, DSQ_SWITCH_ON, DSQ_TRIP_ACT) |=> status_r.contactor;
  endproperty
  a_contactor: assert property (p_contactor)
    else $error("contactor not on");

  property p_contactor_hold;
    (state_r == DSQ_START_DIS) |=>
      (status_r.contactor == $past(status_r.contactor));
  endproperty
  a_contactor_hold: assert property (p_contactor_hold)
    else $error("contactor not held");

  property p_stop_fh;
    (state_r == DSQ_FAST_HALT) [*2] |=> status_r.stopping;
  endproperty
  a_stop_fh: assert property (p_stop_fh)
    else $error("stopping missing in fast halt");

  property p_stop_en;
    (state_r == DSQ_ENABLED) && idle_cmd && !env.stop_done |=>
      status_r.stopping;
  endproperty
  a_stop_en: assert property (p_stop_en)
    else $error("stopping missing in enabled");

  sequence s_jog_start;
    (state_r == DSQ_ENABLED) && cmd.jog && !cmd.run;
  endsequence

  property p_jogging;
    s_jog_start ##1 (state_r == DSQ_ENABLED) |=> status_r.jogging;
  endproperty
  a_jogging: assert property (p_jogging)
    else $error("jogging not raised");

  property p_healthy_tripped;
    (state_r == DSQ_TRIPPED) |=> (status_r.healthy == $past(idle_cmd));
  endproperty
  a_healthy_tripped: assert property (p_healthy_tripped)
    else $error("healthy not restored when idle");

  property p_priority;
    (state_r == DSQ_ENABLED) && !cmd.trip && !cmd.coast_halt_n &&
      !reinit |=> (state_r == DSQ_START_DIS);
  endproperty
  a_priority: assert property (p_priority)
    else $error("coast halt lost priority");

  property p_registered;
    (state_r != DSQ_ENABLED) ##1 (state_r == DSQ_ENABLED) |->
      !status_r.running ##1 status_r.running;
  endproperty
  a_registered: assert property (p_registered)
    else $error("running not one cycle late");

endmodule

// ===== sim/dsq_partner.sv
// Model of the power stack and initialisation logic at the far side.
// Assumes the state code of the sequencer on the same clock.
`timescale 1ns/10ps

module dsq_partner
  import dsq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] state_code,
  input  wire logic       slow,
  output logic            init_done,
  output logic            stack_quenched
);
  // ==========================================================
  // Cycles spent in the present state
  logic [5:0] cnt_r;
  logic [2:0] st_r;
  logic [5:0] dly;
  logic       settled;

  assign dly = slow ? 6'h14 : 6'h01;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= 6'h00;
      st_r  <= 3'h0;
    end else begin
      st_r  <= state_code;
      cnt_r <= (st_r != state_code) ? 6'h00 :
               (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
    end
  end

  // ==========================================================
  // Init completes after a delay; stack quenches after a delay
  assign settled = (st_r == state_code) && (cnt_r >= dly);
  assign init_done = (state_code == 3'h0) ? settled : 1'b1;
  assign stack_quenched = (state_code == 3'h6) ? settled :
                          (state_code < 3'h3 || state_code == 3'h7);
endmodule

// ===== sim/dsq_seq_tb_top.sv
// Self-checking bench of the drive sequencing state machine.
// Assumes the partner model and a 20 MHz clock.
`timescale 1ns/10ps

module dsq_seq_tb_top
  import dsq_pkg::*;
;
  logic        clk, resetn, wr, rd, slow, chk_on;
  logic        fh_exp, at_zero, stop_dn, init_done, quenched;
  dsq_cmd_t    cmd;
  dsq_env_t    env;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, exp_rd, rd_msk;
  logic [2:0]  state_code, exp_st, st_d1;
  dsq_status_t status;
  logic        cont, ct, cm, rcfg, tr_prev;
  logic [8:0]  msk;
  int          mismatches, num_checks, cyc;
  event        mon_done;

  assign env = {init_done, quenched, fh_exp, at_zero, stop_dn};

  dsq_seq uut (.clk(clk), .resetn(resetn), .cmd(cmd), .env(env),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .state_code(state_code), .status(status));

  dsq_partner far (.clk(clk), .resetn(resetn), .state_code(state_code),
    .slow(slow), .init_done(init_done), .stack_quenched(quenched));

  always #25 clk = ~clk;

  // ==========================================================
  // Expected next state and flags
  function automatic logic [2:0] nxt(logic [2:0] s, dsq_cmd_t c,
                                     dsq_env_t e, logic cmo, logic rc,
                                     logic tp);
    logic idle;
    logic halt;
    idle = !c.run && !c.jog;
    halt = !c.coast_halt_n || !c.fast_halt_n;
    nxt = s;
    if (s == 3'h0) begin
      if (e.init_done && !rc) nxt = 3'h1;
    end else if (s <= 3'h5 && c.trip) nxt = 3'h6;
    else case (s)
      3'h1: if (idle && !halt) nxt = 3'h2;
      3'h2: if (halt) nxt = 3'h1; else if (!idle) nxt = 3'h3;
      3'h3: if (halt) nxt = 3'h1; else if (idle) nxt = 3'h2;
            else if (c.drive_enable) nxt = 3'h4;
      3'h4: if (!c.coast_halt_n) nxt = 3'h1;
            else if (!c.fast_halt_n) nxt = 3'h5;
            else if (!c.drive_enable) nxt = 3'h3;
            else if (idle && e.stop_done) nxt = 3'h2;
      3'h5: if (e.fh_timer_expired || cmo || e.at_zero_setpoint) nxt = 3'h1;
      3'h6: if (e.stack_quenched) nxt = 3'h7;
      default: if (!c.trip && c.trip_reset && !tp) nxt = 3'h1;
    endcase
  endfunction

  function automatic logic [8:0] flg(logic [2:0] s, logic k);
    flg = {s >= 3'h6, s == 3'h4, 1'b0, s == 3'h5, k,
           s >= 3'h2 && s <= 3'h6, s >= 3'h3 && s <= 3'h6,
           s >= 3'h3 && s <= 3'h6, s <= 3'h5};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // Monitor: compares, then advances the model
  always @(posedge clk) begin
    ct = (st_d1 >= 3'h3 && st_d1 <= 3'h6) ? 1'b1 :
         (st_d1 == 3'h0 || st_d1 == 3'h7) ? 1'b0 : cont;
    msk = (st_d1 == 3'h4) ? 9'h19F : (st_d1 == 3'h7) ? 9'h1FE : 9'h1FF;
    if (chk_on) begin
      chk("state_code", exp_st, state_code);
      chk("status", flg(st_d1, ct) & msk, status & msk);
    end
    exp_rd = {15'h0, flg(st_d1, ct), 5'h0, exp_st};
    rd_msk = {15'h0, msk, 8'hFF};
    cont = ct;
    st_d1 = exp_st;
    if (!resetn) begin
      exp_st = 3'h0;
      tr_prev = 1'b1;
      cm = 1'b0;
      rcfg = 1'b0;
    end else begin
      exp_st = nxt(exp_st, cmd, env, cm, rcfg, tr_prev);
      if (wr && addr == DSQ_OFS_CTRL && wdata[DSQ_CTRL_REINIT])
        exp_st = 3'h0;
      tr_prev = cmd.trip_reset;
      if (wr && addr == DSQ_OFS_CTRL) begin
        cm = wdata[DSQ_CTRL_COAST_MODE];
        rcfg = wdata[DSQ_CTRL_RECONFIG];
      end
    end
    -> mon_done;
  end

  // ==========================================================
  // Stimulus and bus tasks
  task automatic rnd_cycles(input int n);
    logic [31:0] r;
    dsq_cmd_t    c;
    repeat (n) begin
      @(mon_done);
      r = $urandom;
      c.run = r[0];
      c.jog = r[1] & r[2];
      c.coast_halt_n = |r[6:3];
      c.fast_halt_n = |r[10:7];
      c.trip = &r[15:11];
      c.trip_reset = r[16];
      c.drive_enable = r[17] | r[18];
      if (exp_st == 3'h3 && !c.run && !c.jog) c.drive_enable = 1'b0;
      cmd <= c;
      fh_exp <= &r[21:19];
      at_zero <= &r[24:22];
      stop_dn <= r[25];
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    clk = 0; resetn = 0; wr = 0; rd = 0; slow = 0; chk_on = 0;
    addr = 8'h00; wdata = 32'h0; cmd = '0; cyc = 0;
    fh_exp = 0; at_zero = 0; stop_dn = 0; mismatches = 0; num_checks = 0;
    void'($urandom(32'h8E3F8A0B));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chk_on = 1'b1;
    rnd_cycles(3000);
    $display("test random_fast done");
    @(posedge clk);
    cmd <= 7'b0011000;
    fh_exp <= 1'b1;
    repeat (20) @(posedge clk);
    reg_wr(DSQ_OFS_CTRL, 32'h5);
    reg_wr(8'h08, 32'h6);
    reg_rd(DSQ_OFS_CTRL, d);
    chk("ctrl", 32'h1, d);
    reg_rd(8'h08, d);
    chk("unmapped", 32'h0, d);
    reg_rd(DSQ_OFS_STATUS, d);
    chk("status_reg", exp_rd & rd_msk, d & rd_msk);
    @(posedge clk);
    #1 chk("rdata_idle", 32'h0, rdata);
    $display("test registers done");
    slow = 1'b1;
    rnd_cycles(2000);
    $display("test random_coast_slow done");
    chk_on = 1'b0;
    reg_wr(DSQ_OFS_CTRL, 32'h6);
    repeat (30) @(posedge clk);
    chk("state_reinit", 32'h0, state_code);
    reg_wr(DSQ_OFS_CTRL, 32'h0);
    repeat (40) begin
      @(posedge clk);
      if (state_code === 3'h1) break;
    end
    chk("state_init", 32'h1, state_code);
    $display("test reinit done");
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    chk_on = 1'b1;
    slow = 1'b0;
    rnd_cycles(2000);
    $display("test random_after_reset done");
    print_verdict();
  end
endmodule
